// ===== crpc_cfg.svh
// Constants for the chip reset pin control block.
// Function
// - External reset low holds all device logic except the debug port logic in reset.
// - On external reset release, latch the boot strap as operating mode.
// - Internal reset releases synchronously after a fixed internal clock count.
// - Chip reset alone leaves the debug port logic unreset.
// - Internal power-on reset asserts on initial power-up.
// - Reset pin pull-up on by default and during power-on reset, off when its disable bit set.
// - Reset output mirrors the internal reset state.
`ifndef CRPC_CFG_SVH
`define CRPC_CFG_SVH
`define CRPC_RELEASE_CYCLES 32
`define CRPC_POR_CYCLES 16
`define CRPC_CNT_W 8
`endif

// ===== crpc_pkg.sv
// Types for the chip reset pin control block.
package crpc_pkg;
  typedef enum logic [1:0]
  {
    CRPC_POR  = 2'b00,
    CRPC_HOLD = 2'b01,
    CRPC_WAIT = 2'b10,
    CRPC_RUN  = 2'b11
  } crpc_state_t;
endpackage

// ===== crpc_reset_ctrl.sv
// Chip reset sequencer: combines pin reset and power-on reset, latches boot mode.
`include "crpc_cfg.svh"
module crpc_reset_ctrl
  import crpc_pkg::*;
#(
  parameter int RELEASE_CYCLES = `CRPC_RELEASE_CYCLES,
  parameter int POR_CYCLES     = `CRPC_POR_CYCLES
)
(
  // Clock, reset and enable.
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  // Pins.
  input  wire logic ext_reset_n_i,
  input  wire logic test_reset_n_i,
  input  wire logic external_boot_strap_i,
  // Pull-up control from the pull-up disable register.
  input  wire logic pullup_disable_reg_reset_i,
  // Outputs.
  output logic      int_reset_o,
  output logic      debug_reset_o,
  output logic      boot_mode_o,
  output logic      reset_state_output_o,
  output logic      reset_pullup_en_o
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int CW = `CRPC_CNT_W;

  // Refuse cycle counts that the release counter cannot hold.
  if (RELEASE_CYCLES < 1 || RELEASE_CYCLES >= (1 << CW) || POR_CYCLES < 1 || POR_CYCLES >= (1 << CW))
  begin : g_bad_counts
    $error("crpc_reset_ctrl: cycle counts out of range");
  end

  // Two-stage synchronisers for the pin inputs; only the second stage is read by logic.
  logic [1:0] ext_sync_r, ext_sync_nxt;
  logic [1:0] tst_sync_r, tst_sync_nxt;
  logic [1:0] boot_sync_r, boot_sync_nxt;

  always_comb
  begin
    ext_sync_nxt  = {ext_sync_r[0], ext_reset_n_i};
    tst_sync_nxt  = {tst_sync_r[0], test_reset_n_i};
    boot_sync_nxt = {boot_sync_r[0], external_boot_strap_i};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_sync_r  <= 2'h0;
      tst_sync_r  <= 2'h0;
      boot_sync_r <= 2'h0;
    end
    else if (clk_en_i)
    begin
      ext_sync_r  <= ext_sync_nxt;
      tst_sync_r  <= tst_sync_nxt;
      boot_sync_r <= boot_sync_nxt;
    end
  end

  // A cleared synchroniser reads as a held pin reset until the real pin level has arrived.
  logic ext_asserted;
  assign ext_asserted = !ext_sync_r[1];

  // Sequencer: power-on count, hold while the pin reset is low, release count, run.
  // A pin reset outside the power-on phase sends the sequence back to hold and clears the count.
  crpc_state_t      state_r, state_nxt;
  logic [CW-1:0]    cnt_r, cnt_nxt;
  logic             int_rst_r, int_rst_nxt;
  logic             boot_r, boot_nxt;
  logic             dbg_r, dbg_nxt;
  logic             pu_r, pu_nxt;

  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    int_rst_nxt = int_rst_r;
    boot_nxt    = boot_r;
    dbg_nxt     = !tst_sync_r[1];
    pu_nxt      = !pullup_disable_reg_reset_i;
    unique case (state_r)
      CRPC_POR:
      begin
        int_rst_nxt = 1'b1;
        if (cnt_r == CW'(POR_CYCLES - 1))
        begin
          state_nxt = CRPC_HOLD;
          cnt_nxt   = '0;
        end
        else
          cnt_nxt = cnt_r + CW'(1);
      end
      CRPC_HOLD:
      begin
        int_rst_nxt = 1'b1;
        cnt_nxt     = '0;
        if (!ext_asserted)
        begin
          boot_nxt  = boot_sync_r[1];
          state_nxt = CRPC_WAIT;
        end
      end
      CRPC_WAIT:
      begin
        int_rst_nxt = 1'b1;
        if (ext_asserted)
        begin
          state_nxt = CRPC_HOLD;
          cnt_nxt   = '0;
        end
        else if (cnt_r == CW'(RELEASE_CYCLES - 1))
        begin
          state_nxt   = CRPC_RUN;
          int_rst_nxt = 1'b0;
        end
        else
          cnt_nxt = cnt_r + CW'(1);
      end
      CRPC_RUN:
      begin
        if (ext_asserted)
        begin
          state_nxt   = CRPC_HOLD;
          int_rst_nxt = 1'b1;
          cnt_nxt     = '0;
        end
      end
    endcase
  end

  // Synchronous reset models the power-on event.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r   <= CRPC_POR;
      cnt_r     <= '0;
      int_rst_r <= 1'b1;
      boot_r    <= 1'b0;
      dbg_r     <= 1'b1;
      pu_r      <= 1'b1;
    end
    else if (clk_en_i)
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      int_rst_r <= int_rst_nxt;
      boot_r    <= boot_nxt;
      dbg_r     <= dbg_nxt;
      pu_r      <= pu_nxt;
    end
  end

  // The reset state output and the internal reset share one flop so they can never disagree.
  assign int_reset_o          = int_rst_r;
  assign reset_state_output_o = int_rst_r;
  assign debug_reset_o        = dbg_r;
  assign boot_mode_o          = boot_r;
  assign reset_pullup_en_o    = pu_r;

  // Checks watch registered signals, synchronised pins, the clock enable, the reset and the pull-up disable input.
  a_hold_in_reset: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && ext_asserted |=> int_reset_o)
    else $error("internal reset not held during external reset");
  a_boot_latch: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_r == CRPC_HOLD && !ext_asserted |=> boot_mode_o == $past(boot_sync_r[1]))
    else $error("boot mode not latched on release");
  a_boot_stable: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !(state_r == CRPC_HOLD && !ext_asserted) |=> $stable(boot_mode_o))
    else $error("boot mode changed outside a release");

  a_release_delay: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(int_reset_o) |-> $past(state_r) == CRPC_WAIT && $past(cnt_r) == CW'(RELEASE_CYCLES - 1))
    else $error("internal reset released early");
  a_wait_count: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_r == CRPC_WAIT && !ext_asserted && cnt_r != CW'(RELEASE_CYCLES - 1)
      |=> state_r == CRPC_WAIT && int_reset_o && cnt_r == $past(cnt_r) + CW'(1))
    else $error("release count skipped or stalled");

  a_debug_indep: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && tst_sync_r[1] |=> !debug_reset_o)
    else $error("debug logic reset without test reset");
  a_debug_follow: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && !tst_sync_r[1] |=> debug_reset_o)
    else $error("debug logic not reset during test reset");

  a_por_start: assert property (
    @(posedge sys_clk_i)
    !rst_n_i |=> int_reset_o && state_r == CRPC_POR)
    else $error("power-on reset not asserted");
  a_por_length: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(state_r) == CRPC_POR && state_r != CRPC_POR |-> $past(cnt_r) == CW'(POR_CYCLES - 1))
    else $error("power-on phase ended early");

  a_pullup_ctrl: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i |=> reset_pullup_en_o == !$past(pullup_disable_reg_reset_i))
    else $error("pull-up enable wrong");
  a_state_out_mirror: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    reset_state_output_o == int_reset_o && reset_state_output_o == (state_r != CRPC_RUN))
    else $error("reset output differs from internal reset state");

  a_restart_cnt: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && ext_asserted && state_r != CRPC_POR |=> cnt_r == '0 && state_r == CRPC_HOLD)
    else $error("release counter not restarted");

  a_freeze_state: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !clk_en_i |=> $stable(state_r) && $stable(cnt_r) && $stable(int_reset_o) && $stable(boot_mode_o))
    else $error("state moved while the clock enable was low");
endmodule

// ===== crpc_pins.sv
// Pin-side model of the reset circuitry, debugger and boot strap.
module crpc_pins
(
  // Commands from the bench.
  input  wire logic full_i,
  input  wire logic dbg_i,
  input  wire logic boot_i,
  // Pins.
  output logic      ext_reset_n_o,
  output logic      test_reset_n_o,
  output logic      boot_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign ext_reset_n_o  = !(full_i || dbg_i);
  assign test_reset_n_o = !full_i;
  assign boot_o         = boot_i;
endmodule

// ===== tb_top.sv
// Self-checking bench for the chip reset sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_n_i   = 1'b0;
  logic full      = 1'b0;
  logic dbg       = 1'b0;
  logic boot      = 1'b0;
  logic pud       = 1'b0;
  logic en        = 1'b1;
  localparam int REL_CYC = 4;
  localparam int POR_CYC = 2;
  localparam int PIN_REL = 3 + REL_CYC;
  localparam int POR_REL = POR_CYC + 1 + REL_CYC;
  logic ext_n, tst_n, strap, int_rst, dbg_rst, boot_mode, rso, pu_en;
  int   n_mismatch = 0;
  int   checked    = 0;
  int   n;
  always #50 sys_clk_i = ~sys_clk_i;
  crpc_pins pins (.full_i(full), .dbg_i(dbg), .boot_i(boot), .ext_reset_n_o(ext_n),
    .test_reset_n_o(tst_n), .boot_o(strap));
  crpc_reset_ctrl #(.RELEASE_CYCLES(REL_CYC), .POR_CYCLES(POR_CYC)) dut (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(en), .ext_reset_n_i(ext_n), .test_reset_n_i(tst_n),
    .external_boot_strap_i(strap), .pullup_disable_reg_reset_i(pud), .int_reset_o(int_rst),
    .debug_reset_o(dbg_rst), .boot_mode_o(boot_mode), .reset_state_output_o(rso),
    .reset_pullup_en_o(pu_en));
  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %b expected %b", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic chk_int(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  // Counts cycles until the internal reset drops, checking the reset output on each one.
  task automatic wait_rel(output int k);
    k = 0;
    while (int_rst !== 1'b0 && k < 40)
    begin
      cyc(1);
      k++;
      chk(rso, int_rst);
    end
    if (int_rst !== 1'b0)
    begin
      n_mismatch++;
      end_sim();
    end
  endtask
  task automatic t_full(input logic b);
    full = 1'b1;
    boot = b;
    cyc(4);
    chk(int_rst, 1'b1);
    chk(dbg_rst, 1'b1);
    full = 1'b0;
    wait_rel(n);
    chk_int(n, PIN_REL);
    chk(boot_mode, b);
    boot = ~b;
    cyc(4);
    chk(boot_mode, b);
  endtask
  task automatic t_dbg;
    dbg = 1'b1;
    cyc(4);
    chk(int_rst, 1'b1);
    chk(dbg_rst, 1'b0);
    dbg = 1'b0;
    wait_rel(n);
    chk_int(n, PIN_REL);
    chk(dbg_rst, 1'b0);
  endtask
  task automatic t_restart;
    full = 1'b1;
    cyc(4);
    full = 1'b0;
    cyc(3);
    full = 1'b1;
    cyc(3);
    chk(int_rst, 1'b1);
    full = 1'b0;
    wait_rel(n);
    chk_int(n, PIN_REL);
  endtask
  task automatic t_pullup;
    pud = 1'b1;
    cyc(3);
    chk(pu_en, 1'b0);
    pud = 1'b0;
    cyc(3);
    chk(pu_en, 1'b1);
  endtask
  // Clock enable low in the middle of the release count must hold the count.
  task automatic t_freeze;
    full = 1'b1;
    cyc(4);
    full = 1'b0;
    cyc(4);
    en = 1'b0;
    cyc(8);
    chk(int_rst, 1'b1);
    en = 1'b1;
    wait_rel(n);
    chk_int(n, REL_CYC - 1);
  endtask
  // Power-on reset in mid-run, with boot mode high and the pull-up disable bit set.
  task automatic t_por;
    pud = 1'b1;
    rst_n_i = 1'b0;
    cyc(2);
    chk(int_rst, 1'b1);
    chk(rso, 1'b1);
    chk(dbg_rst, 1'b1);
    chk(boot_mode, 1'b0);
    chk(pu_en, 1'b1);
    pud = 1'b0;
    rst_n_i = 1'b1;
    wait_rel(n);
    chk_int(n, POR_REL);
  endtask
  initial
  begin
    cyc(10);
    rst_n_i = 1'b1;
    chk(int_rst, 1'b1);
    chk(pu_en, 1'b1);
    wait_rel(n);
    chk_int(n, POR_REL);
    t_full(1'b1);
    t_full(1'b0);
    t_dbg();
    t_restart();
    t_pullup();
    t_freeze();
    t_full(1'b1);
    t_por();
    end_sim();
  end
endmodule
